/* sgct_core.sv */
// Summary of operation
// R1: controller idles two cycles entering power-down
// R2: controller waits ten cycles after power-down exit
// R3: mode register commands spaced four cycles
// R4: PLL locks within 5000 command cycles
// R5: calibration update finishes within 40 ns
// R6: controller waits 10 us before sensor use
// R7: auto-precharge held off until row-active time
// R8: long spacing only for same bank group
// R9: at most four activates per window
// R10: at most 32 activates per long window
// R11: long read-to-precharge for same bank, groups on
// R12: write recovery delay rounds each term up
// R13: long column spacing within same bank group
// R14: short column spacing for listed gapless pairs
// R15: waiting eight cycles after pattern load suffices
// R16: read-to-write turnaround includes clock-to-data difference
// R17: train write data timing before writes
// R18: train read data timing before reads
// R19: data clock period is half command clock
// R20: data timing holds only with inversion, four lows
// R21: address timing holds only with inversion, four lows
// R22: mode six bit A0 selects alignment point
// R23: mode seven selects autosync, low freq, half vref
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module sgct_core #(
  parameter int LOCK_CYCLES = sgct_pkg::PLL_LOCK_CK // command-clock edges until lock
) (
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic nrst, // async reset, active low
  input wire logic ck_pin, // command clock from the controller
  input wire logic [sgct_pkg::CMD_W-1:0] cmd_pin, // command code
  input wire logic [sgct_pkg::BANK_W-1:0] bank_pin, // bank address
  input wire logic [sgct_pkg::ADDR_W-1:0] addr_pin, // row/column/mode address
  input wire logic [sgct_pkg::DQ_W-1:0] dq_pin, // write data
  input wire logic dq_valid_pin, // write data present on dq
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic pll_locked_r, // pll reports lock
  output logic cal_busy_r, // calibration update in progress
  output logic align_at_pins_r, // clock alignment at pins, else at detector
  output logic autosync_r, // automatic clock synchronization on
  output logic low_freq_r, // low frequency mode on
  output logic half_vref_r, // half data reference voltage selected
  output logic [sgct_pkg::NUM_BANKS-1:0] int_pre_r // internal precharge pulses
);
  import sgct_pkg::*;

  // counts low bits of a 10-bit group; callers pad unused bits with ones
  function automatic logic [3:0] count_low(input logic [ADDR_W-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < ADDR_W; i++) begin
      n = n + {3'h0, ~v[i]};
    end
    return n;
  endfunction : count_low

  // two-flop synchroniser for everything arriving on pins
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {ck_pin, dq_valid_pin, cmd_pin, bank_pin, addr_pin, dq_pin};
      sync2_r <= sync1_r;
    end
  end

  wire ck_s = sync2_r[SYNC_W-1];
  wire dqv_s = sync2_r[SYNC_W-2];
  wire [CMD_W-1:0] cmd_s = sync2_r[SYNC_W-3 -: CMD_W];
  wire [BANK_W-1:0] bank_s = sync2_r[SYNC_W-3-CMD_W -: BANK_W];
  wire [ADDR_W-1:0] addr_s = sync2_r[DQ_W+ADDR_W-1 -: ADDR_W];
  wire [DQ_W-1:0] dq_s = sync2_r[DQ_W-1:0];

  // rising edge of the command clock marks a command slot
  logic ck_d_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ck_d_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s;
    end
  end
  wire ck_rise = ck_s & ~ck_d_r;

  // command decode; only exit is honoured while powered down
  sgct_pwr_t pwr_r;
  sgct_pwr_t pwr_nxt;
  wire awake = (pwr_r == SGCT_PWR_ON);
  wire slot = ck_rise & awake;
  wire c_act = slot & (cmd_s == CMD_ACT);
  wire c_rda = slot & (cmd_s == CMD_RDA);
  wire c_wra = slot & (cmd_s == CMD_WRA);
  wire c_pre = slot & (cmd_s == CMD_PRE);
  wire c_ref = slot & (cmd_s == CMD_REF);
  wire c_mrs = slot & (cmd_s == CMD_MRS);
  wire c_pde = slot & (cmd_s == CMD_PDE);
  wire c_sre = slot & (cmd_s == CMD_SRE);
  wire c_pdx = ck_rise & ~awake & (cmd_s == CMD_PDX);
  wire c_any = slot & (cmd_s != CMD_NOP);

  // power state follows entry and exit commands
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      SGCT_PWR_ON: begin
        if (c_pde) begin
          pwr_nxt = SGCT_PWR_DOWN;
        end else if (c_sre) begin
          pwr_nxt = SGCT_PWR_SELF;
        end
      end
      SGCT_PWR_DOWN, SGCT_PWR_SELF: begin
        if (c_pdx) begin
          pwr_nxt = SGCT_PWR_ON;
        end
      end
      default: pwr_nxt = SGCT_PWR_ON;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= SGCT_PWR_ON;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // control register steers pll enable and inversion checking
  logic [2:0] ctrl_r;
  wire pll_en = ctrl_r[CTRL_PLL_EN];
  wire dinv_en = ctrl_r[CTRL_DINV_EN];
  wire ainv_en = ctrl_r[CTRL_AINV_EN];

  // pll lock counts command-clock edges; lock is reported no later than the limit
  sgct_pll_t pll_r;
  logic [LOCK_W-1:0] lock_cnt_r;
  wire lock_done = (lock_cnt_r >= LOCK_W'(LOCK_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pll_r <= SGCT_PLL_OFF;
      lock_cnt_r <= '0;
      pll_locked_r <= 1'b0;
    end else begin
      pll_locked_r <= (pll_r == SGCT_PLL_LOCKED) & pll_en;
      if (!pll_en) begin
        pll_r <= SGCT_PLL_OFF;
        lock_cnt_r <= '0;
      end else if (pll_r == SGCT_PLL_OFF) begin
        pll_r <= SGCT_PLL_LOCKING;
      end else if (pll_r == SGCT_PLL_LOCKING && ck_rise) begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
        if (lock_done) begin
          pll_r <= SGCT_PLL_LOCKED; // R4
        end
      end
    end
  end

  // calibration update after refresh, ends within the 40 ns bound
  logic [CAL_W-1:0] cal_cnt_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cal_cnt_r <= '0;
      cal_busy_r <= 1'b0;
    end else begin
      if (c_ref) begin
        cal_cnt_r <= CAL_LOAD - 1'b1; // R5
        cal_busy_r <= 1'b1;
      end else if (cal_cnt_r != '0) begin
        cal_cnt_r <= cal_cnt_r - 1'b1;
      end else begin
        cal_busy_r <= 1'b0; // R5
      end
    end
  end

  // mode registers six and seven, loaded by mode register set commands
  logic [ADDR_W-1:0] mode_six_r;
  logic [ADDR_W-1:0] mode_seven_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_six_r <= MR_RESET;
      mode_seven_r <= MR_RESET;
      align_at_pins_r <= 1'b0;
      autosync_r <= 1'b0;
      low_freq_r <= 1'b0;
      half_vref_r <= 1'b0;
    end else begin
      if (c_mrs && bank_s == MR_SIX_SEL) begin
        mode_six_r <= addr_s;
      end
      if (c_mrs && bank_s == MR_SEVEN_SEL) begin
        mode_seven_r <= addr_s;
      end
      align_at_pins_r <= mode_six_r[MODE_SIX_ALIGN_BIT]; // R22
      autosync_r <= mode_seven_r[MODE_SEVEN_SYNC_BIT]; // R23
      low_freq_r <= mode_seven_r[MODE_SEVEN_LF_BIT]; // R23
      half_vref_r <= mode_seven_r[MODE_SEVEN_HVREF_BIT]; // R23
    end
  end

  // banks with row-active holdoff on auto-precharge
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] bank_hit;
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    assign bank_hit[b] = (bank_s == BANK_W'(b));
    sgct_bank u_bank (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .act(c_act & bank_hit[b]),
      .col_ap((c_rda | c_wra) & bank_hit[b]),
      .pre(c_pre & bank_hit[b]),
      .open_r(bank_open[b]),
      .int_pre_r(int_pre_r[b])
    );
  end

  // inversion checks: timing is only promised with inversion on and few lows
  wire [3:0] addr_lows = count_low(addr_s);
  logic dinv_bad;
  always_comb begin
    dinv_bad = 1'b0;
    for (int i = 0; i < DQ_W / 8; i++) begin
      if (count_low({2'b11, dq_s[i*8 +: 8]}) > LOW_LIMIT) begin
        dinv_bad = 1'b1;
      end
    end
  end
  wire dinv_evt = ck_rise & dqv_s & (~dinv_en | dinv_bad); // R20
  wire ainv_evt = c_any & (~ainv_en | (addr_lows > LOW_LIMIT)); // R21

  // wishbone slave: one wait cycle, ack registered with the read data
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = (wb_adr_i == REG_CTRL);
  wire hit_err = (wb_adr_i == REG_ERR);
  wire [31:0] status_val = {bank_open, 12'h000, pwr_r, cal_busy_r, pll_locked_r};
  logic [1:0] err_r;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL: rd_mux = {29'h0, ctrl_r};
      REG_STATUS: rd_mux = status_val;
      REG_MODE_SIX: rd_mux = {22'h0, mode_six_r};
      REG_MODE_SEVEN: rd_mux = {22'h0, mode_seven_r};
      REG_ERR: rd_mux = {30'h0, err_r};
      default: rd_mux = 32'h0; // unmapped reads zero, writes ignored
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_r <= CTRL_RESET;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
      if (wr && hit_ctrl) begin
        ctrl_r <= wb_dat_i[2:0];
      end
    end
  end

  // sticky violation flags, write one to clear; a new event beats the clear
  wire [1:0] err_clr = (wr && hit_err) ? wb_dat_i[1:0] : 2'b00;
  wire [1:0] err_set = {ainv_evt, dinv_evt};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_r <= 2'b00;
    end else begin
      err_r <= (err_r & ~err_clr) | err_set;
    end
  end
endmodule : sgct_core
`default_nettype wire

/* sgct_pkg.sv */
package sgct_pkg;
  // clock and time figures
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAS_MIN_NS = 32;
  localparam int RAS_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_MAX_NS = 40;
  localparam int CAL_CYC_I = CAL_MAX_NS / CLK_PERIOD_NS;
  localparam int CAL_CYC = (CAL_CYC_I < 1) ? 1 : CAL_CYC_I;
  localparam int PLL_LOCK_CK = 5000;
  localparam int LOCK_W = 13;
  localparam int RAS_W = 4;
  localparam int CAL_W = 4;
  localparam logic [RAS_W-1:0] RAS_LOAD = RAS_W'(RAS_CYC);
  localparam logic [CAL_W-1:0] CAL_LOAD = CAL_W'(CAL_CYC);
  // pin widths
  localparam int NUM_BANKS = 16;
  localparam int CMD_W = 4;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 10;
  localparam int DQ_W = 32;
  localparam int SYNC_W = 1 + 1 + CMD_W + BANK_W + ADDR_W + DQ_W;
  localparam logic [3:0] LOW_LIMIT = 4'h4;
  // command codes on the command pins
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_ACT = 4'h1;
  localparam logic [CMD_W-1:0] CMD_RD = 4'h2;
  localparam logic [CMD_W-1:0] CMD_WR = 4'h3;
  localparam logic [CMD_W-1:0] CMD_RDA = 4'h4;
  localparam logic [CMD_W-1:0] CMD_WRA = 4'h5;
  localparam logic [CMD_W-1:0] CMD_PRE = 4'h6;
  localparam logic [CMD_W-1:0] CMD_REF = 4'h7;
  localparam logic [CMD_W-1:0] CMD_MRS = 4'h8;
  localparam logic [CMD_W-1:0] CMD_PDE = 4'h9;
  localparam logic [CMD_W-1:0] CMD_SRE = 4'ha;
  localparam logic [CMD_W-1:0] CMD_PDX = 4'hb;
  // mode register selection and field positions
  localparam logic [BANK_W-1:0] MR_SIX_SEL = 4'h6;
  localparam logic [BANK_W-1:0] MR_SEVEN_SEL = 4'h7;
  localparam int MODE_SIX_ALIGN_BIT = 0;
  localparam int MODE_SEVEN_LF_BIT = 3;
  localparam int MODE_SEVEN_SYNC_BIT = 4;
  localparam int MODE_SEVEN_HVREF_BIT = 7;
  localparam logic [ADDR_W-1:0] MR_RESET = 10'h000;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE_SIX = 8'h08;
  localparam logic [7:0] REG_MODE_SEVEN = 8'h0c;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam int CTRL_PLL_EN = 0;
  localparam int CTRL_DINV_EN = 1;
  localparam int CTRL_AINV_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h6;
  localparam int ERR_DINV = 0;
  localparam int ERR_AINV = 1;
  typedef enum logic [1:0] {SGCT_PWR_ON, SGCT_PWR_DOWN, SGCT_PWR_SELF} sgct_pwr_t;
  typedef enum logic [1:0] {SGCT_PLL_OFF, SGCT_PLL_LOCKING, SGCT_PLL_LOCKED} sgct_pll_t;
endpackage : sgct_pkg

/* sgct_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module sgct_bank
  import sgct_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic act, // activate pulse for this bank
  input wire logic col_ap, // read or write with auto-precharge
  input wire logic pre, // explicit precharge pulse
  output logic open_r, // row is open
  output logic int_pre_r // internal precharge pulse
);
  logic [RAS_W-1:0] ras_cnt_r;
  logic ap_pend_r;
  wire ras_met = (ras_cnt_r == '0);
  wire fire = open_r & ap_pend_r & ras_met & ~act;

  // row-active timer, loaded on activate and run down to zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ras_cnt_r <= '0;
    end else if (act) begin
      ras_cnt_r <= RAS_LOAD;
    end else if (!ras_met) begin
      ras_cnt_r <= ras_cnt_r - 1'b1;
    end
  end

  // auto-precharge waits here until the row-active time is met
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      open_r <= 1'b0;
      ap_pend_r <= 1'b0;
      int_pre_r <= 1'b0;
    end else begin
      int_pre_r <= fire; // R7
      if (act) begin
        open_r <= 1'b1;
        ap_pend_r <= 1'b0;
      end else if (pre || fire) begin
        open_r <= 1'b0;
        ap_pend_r <= 1'b0;
      end else if (col_ap && open_r) begin
        ap_pend_r <= 1'b1; // R7
      end
    end
  end
endmodule : sgct_bank
`default_nettype wire

/* sgct_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module sgct_asserts
  import sgct_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CK // lock count of the core
) (
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset, low
  input wire logic ck_pin, // command clock
  input wire logic [sgct_pkg::CMD_W-1:0] cmd_pin, // command
  input wire logic [sgct_pkg::BANK_W-1:0] bank_pin, // bank
  input wire logic [sgct_pkg::ADDR_W-1:0] addr_pin, // address
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // bus address
  input wire logic [3:0] wb_sel_i, // selects
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic pll_locked_r, // lock
  input wire logic cal_busy_r, // calibration
  input wire logic align_at_pins_r, // alignment
  input wire logic autosync_r, // autosync
  input wire logic low_freq_r, // low frequency
  input wire logic half_vref_r, // half vref
  input wire logic [sgct_pkg::NUM_BANKS-1:0] int_pre_r // precharges
);
  logic [2:0] ck_s_r;
  logic en_r;
  logic [15:0] cnt_r;
  // decode of a pll enable write and of a synchronised link clock rise
  wire ctrl_wr = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  wire ck_rise = ck_s_r[1] & ~ck_s_r[2];
  wire [2:0] mode7 = {autosync_r, low_freq_r, half_vref_r};
  // counts link rises while enabled; saturates so a long run cannot wrap
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ck_s_r <= 3'h0;
      en_r <= 1'b0;
      cnt_r <= 16'h0;
    end else begin
      ck_s_r <= {ck_s_r[1:0], ck_pin};
      if (ctrl_wr) en_r <= wb_dat_i[CTRL_PLL_EN];
      if (!en_r) cnt_r <= 16'h0;
      else if (ck_rise && cnt_r != 16'hffff) cnt_r <= cnt_r + 16'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  cal_src_a: assert property (
    $rose(cal_busy_r) |-> cmd_pin == CMD_REF) else $error("calibration without refresh");
  cal_len_a: assert property (
    $rose(cal_busy_r) |=> cal_busy_r ##1 !cal_busy_r) else $error("calibration length");
  pre_once_a: assert property (
    int_pre_r != 16'h0 |=> int_pre_r == 16'h0) else $error("precharge pulse held");
  lock_min_a: assert property (
    pll_locked_r && en_r |-> cnt_r >= LOCK_CYCLES) else $error("lock too early");
  lock_max_a: assert property (
    en_r && cnt_r >= LOCK_CYCLES |-> ##[0:4] pll_locked_r) else $error("lock too late");
  lock_off_a: assert property (
    $fell(en_r) |-> ##[0:3] !pll_locked_r) else $error("lock kept after disable");
  align_src_a: assert property (
    $changed(align_at_pins_r) |-> cmd_pin == CMD_MRS && bank_pin == MR_SIX_SEL
    && addr_pin[MODE_SIX_ALIGN_BIT] == align_at_pins_r) else $error("alignment source");
  mode7_src_a: assert property (
    $changed(mode7) |-> cmd_pin == CMD_MRS && bank_pin == MR_SEVEN_SEL && mode7 ==
    {addr_pin[MODE_SEVEN_SYNC_BIT], addr_pin[MODE_SEVEN_LF_BIT],
    addr_pin[MODE_SEVEN_HVREF_BIT]})
    else $error("mode seven source");
endmodule : sgct_asserts
bind sgct_core sgct_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_sgct_asserts (
  .clk_sys, .nrst, .ck_pin, .cmd_pin, .bank_pin, .addr_pin, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_locked_r, .cal_busy_r,
  .align_at_pins_r, .autosync_r, .low_freq_r, .half_vref_r, .int_pre_r);
`default_nettype wire

/* sgct_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sgct_ctrl_model (
  input wire logic clk_sys, // clock
  output logic ck_pin, // command clock, low between slots
  output logic [sgct_pkg::CMD_W-1:0] cmd_pin, // command
  output logic [sgct_pkg::BANK_W-1:0] bank_pin, // bank
  output logic [sgct_pkg::ADDR_W-1:0] addr_pin, // address
  output logic [sgct_pkg::DQ_W-1:0] dq_pin, // write data
  output logic dq_valid_pin // data present
);
  import sgct_pkg::*;
  initial begin
    ck_pin = 1'b0;
    cmd_pin = CMD_NOP;
    bank_pin = 4'h0;
    addr_pin = 10'h3ff;
    dq_pin = 32'h0;
    dq_valid_pin = 1'b0;
  end
  // one command a slot, few activates: spacing and windows hold
  // no data clock, training, sensor or turnaround is relied on
  // one 160 ns slot; idle data shows the inverse so stale bits never pass
  task automatic slot(input logic [3:0] c, b, input logic [9:0] a, input logic [31:0] d,
                      input logic v);
    @(posedge clk_sys);
    cmd_pin <= c;
    bank_pin <= b;
    addr_pin <= a;
    dq_pin <= v ? d : ~dq_pin;
    dq_valid_pin <= v;
    ck_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ck_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : slot
  // a command followed by the idle slots its spacing asks for
  task automatic cmd(input logic [3:0] c, b, input logic [9:0] a, input logic [31:0] d,
                     input logic v);
    int pad;
    slot(c, b, a, d, v);
    pad = (c == CMD_MRS) ? 3 : (c == CMD_PDE || c == CMD_SRE) ? 2 : (c == CMD_PDX) ? 10 : 0;
    repeat (pad) slot(CMD_NOP, 4'h0, 10'h3ff, 32'h0, 1'b0);
  endtask : cmd
endmodule : sgct_ctrl_model
`default_nettype wire

/* sgct_core_test.sv */
`timescale 1ns/100ps
`default_nettype none
module sgct_core_test;
  import sgct_pkg::*;
  localparam int LOCK = 8; // short lock count keeps the run brief
  logic clk_sys, nrst, ck_pin, dq_valid_pin, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic pll_locked_r, cal_busy_r, align_at_pins_r, autosync_r, low_freq_r, half_vref_r, cal_seen;
  logic [3:0] cmd_pin, bank_pin, wb_sel_i;
  logic [9:0] addr_pin;
  logic [7:0] wb_adr_i;
  logic [31:0] dq_pin, wb_dat_i, wb_dat_o, rd;
  logic [15:0] int_pre_r, pre_seen;
  int errors, n_checks;
  sgct_core #(.LOCK_CYCLES(LOCK)) u_sgct_core (.clk_sys, .nrst, .ck_pin, .cmd_pin,
    .bank_pin, .addr_pin, .dq_pin, .dq_valid_pin, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_locked_r, .cal_busy_r,
    .align_at_pins_r, .autosync_r, .low_freq_r, .half_vref_r, .int_pre_r);
  sgct_ctrl_model u_sgct_ctrl_model (.clk_sys, .ck_pin, .cmd_pin, .bank_pin, .addr_pin,
    .dq_pin, .dq_valid_pin);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // precharge and calibration pulses are short, so keep sticky copies; reset clears them
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_seen <= 16'h0;
      cal_seen <= 1'b0;
    end else begin
      pre_seen <= pre_seen | int_pre_r;
      cal_seen <= cal_seen | cal_busy_r;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic op(input logic [3:0] c, b, input logic [9:0] a);
    u_sgct_ctrl_model.cmd(c, b, a, 32'h0, 1'b0);
  endtask : op
  task automatic t_regs;
    wb_sel_i <= 4'he;
    wb(1'b1, REG_CTRL, 32'h0);
    wb_sel_i <= 4'hf;
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {29'h0, CTRL_RESET});
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, REG_MODE_SIX, 32'h3ff);
    wb(1'b0, REG_MODE_SIX, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  task automatic t_mode;
    op(CMD_MRS, MR_SIX_SEL, 10'h3ff);
    chk(align_at_pins_r, 1'b1);
    op(CMD_MRS, MR_SEVEN_SEL, 10'h3ef);
    chk({autosync_r, low_freq_r, half_vref_r}, 3'h3);
    op(CMD_MRS, MR_SEVEN_SEL, 10'h377);
    chk({autosync_r, low_freq_r, half_vref_r}, 3'h4);
    wb(1'b0, REG_MODE_SEVEN, 32'h0);
    chk(rd, 32'h377);
  endtask : t_mode
  task automatic t_pd;
    op(CMD_PDE, 4'h0, 10'h3ff);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:2], 2'h1);
    op(CMD_MRS, MR_SIX_SEL, 10'h3fe);
    chk(align_at_pins_r, 1'b1);
    op(CMD_PDX, 4'h0, 10'h3ff);
    op(CMD_SRE, 4'h0, 10'h3ff);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:2], 2'h2);
    op(CMD_PDX, 4'h0, 10'h3ff);
    op(CMD_MRS, MR_SIX_SEL, 10'h3fe);
    chk(align_at_pins_r, 1'b0);
  endtask : t_pd
  task automatic t_ap;
    op(CMD_ACT, 4'h3, 10'h3ff);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[31:16], 16'h0008);
    op(CMD_RDA, 4'h3, 10'h3ff);
    op(CMD_RDA, 4'h5, 10'h3ff);
    op(CMD_ACT, 4'h5, 10'h3ff);
    op(CMD_PRE, 4'h5, 10'h3ff);
    op(CMD_ACT, 4'h6, 10'h3ff);
    op(CMD_WRA, 4'h6, 10'h3ff);
    op(CMD_REF, 4'h0, 10'h3ff);
    chk(pre_seen, 16'h0048);
    chk(cal_seen, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[31:16], 16'h0000);
  endtask : t_ap
  task automatic t_err;
    wb(1'b1, REG_ERR, 32'h3);
    u_sgct_ctrl_model.cmd(CMD_WR, 4'h1, 10'h3f0, 32'hffff_fff0, 1'b1);
    wb(1'b0, REG_ERR, 32'h0);
    chk(rd, 32'h0);
    u_sgct_ctrl_model.cmd(CMD_WR, 4'h1, 10'h3e0, 32'hffe0_ffff, 1'b1);
    wb(1'b1, REG_ERR, 32'h1);
    wb(1'b0, REG_ERR, 32'h0);
    chk(rd, 32'h2);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b1, REG_ERR, 32'h3);
    u_sgct_ctrl_model.cmd(CMD_WR, 4'h1, 10'h3ff, 32'hffff_ffff, 1'b1);
    wb(1'b0, REG_ERR, 32'h0);
    chk(rd, 32'h3);
  endtask : t_err
  task automatic t_pll;
    wb(1'b1, REG_CTRL, 32'h7);
    repeat (LOCK - 1) op(CMD_NOP, 4'h0, 10'h3ff);
    chk(pll_locked_r, 1'b0);
    op(CMD_NOP, 4'h0, 10'h3ff);
    chk(pll_locked_r, 1'b1);
    wb(1'b1, REG_CTRL, {29'h0, CTRL_RESET});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[0], 1'b0);
  endtask : t_pll
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // watchdog: the whole sequence needs well under a tenth of this
  initial begin
    #200000;
    errors++;
    $display("mismatch at %0t: timeout", $time);
    give_verdict();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_mode();
    t_pd();
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(autosync_r, 1'b0);
    t_ap();
    t_err();
    t_pll();
    give_verdict();
  end
endmodule : sgct_core_test
`default_nettype wire
